//--- bench/hub_error_sink.sv
// Hub-side sink that counts system-error message requests
`timescale 1ns/1ps
module hub_error_sink (
  input  wire logic clock,
  input  wire logic sysErrMessageReq,
  output int        msgCount
);
  initial msgCount = 0;
  // Each request cycle is one message packet
  always @(posedge clock) begin
    if (sysErrMessageReq) begin
      msgCount <= msgCount + 1;
    end
  end
endmodule // hub_error_sink

//--- bench/test_host_bridge_command_status_regs.sv
// Random self-checking bench for the bridge command and status registers
`timescale 1ns/1ps
module test_host_bridge_command_status_regs;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  cfgAddr = 8'h00;
  logic        cfgRead = 1'b0;
  logic        cfgWrite = 1'b0;
  logic [1:0]  cfgByteEn = 2'h0;
  logic [15:0] cfgWriteData = 16'h0000;
  logic        errorConditionEnabled = 1'b0;
  logic        secondFuncSysErrEnable = 1'b0;
  logic        masterAbortReceived = 1'b0;
  logic        targetAbortReceived = 1'b0;
  wire  [15:0] cfgReadData;
  wire         cfgReadValid;
  wire         sysErrMessageReq;
  wire         systemErrorEnable;
  int          msgCount;
  int          nErrors = 0;
  int          checkCount = 0;
  int          modelMsgs = 0;
  logic        cmdEn = 1'b0;
  logic        expValid = 1'b0;
  logic        expMsg = 1'b0;
  logic [15:0] expData = 16'h0000;
  logic [15:0] flg = 16'h0000;
  logic [15:0] setMask;
  logic [15:0] clrMask;

  always #10 clock = ~clock;

  host_bridge_command_status_regs dut (.clock, .sys_rst, .cfgAddr, .cfgRead, .cfgWrite, .cfgByteEn,
    .cfgWriteData, .cfgReadData, .cfgReadValid, .errorConditionEnabled, .secondFuncSysErrEnable,
    .masterAbortReceived, .targetAbortReceived, .sysErrMessageReq, .systemErrorEnable);
  hub_error_sink hub (.clock, .sysErrMessageReq, .msgCount);

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks=%0d mismatches=%0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    nErrors++;
    close_out;
  end

  // ----------------------------------------
  // Random traffic against the bench model
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    void'($urandom(32'h1ED15761));
    repeat (6) @(posedge clock);
    for (int i = 0; i < 600; i++) begin
      @(negedge clock);
      sys_rst = (i == 300);
      check(cfgReadValid, expValid);
      check(cfgReadData, expData);
      check(sysErrMessageReq, expMsg);
      check(systemErrorEnable, cmdEn);
      if (expMsg) modelMsgs++;
      r = $urandom;
      cfgRead = (i < 2) | (i == 301) | (i == 302) | r[2];
      cfgWrite = r[1];
      cfgAddr = (i == 0 || i == 301) ? 8'h04 : (i == 1 || i == 302) ? 8'h06 :
        (r[4:3] == 2'h0) ? r[31:24] : (r[3] ? 8'h04 : 8'h06);
      cfgByteEn = r[6:5];
      cfgWriteData = 16'($urandom);
      errorConditionEnabled = r[7];
      secondFuncSysErrEnable = r[8] & r[9];
      masterAbortReceived = r[10] & r[11] & r[12];
      targetAbortReceived = r[13] & r[14] & r[15];
      if (sys_rst) begin
        {expValid, expMsg, cmdEn, expData, flg} = '0;
      end else begin
        expValid = cfgRead;
        expData = !cfgRead ? 16'h0000 : (cfgAddr == bridge_regs_pkg::BRIDGE_COMMAND_OFS) ?
          (bridge_regs_pkg::BRIDGE_COMMAND_RST | {7'h00, cmdEn, 8'h00}) :
          (cfgAddr == bridge_regs_pkg::BRIDGE_STATUS_OFS) ? (bridge_regs_pkg::BRIDGE_STATUS_RST | flg) : 16'h0000;
        setMask = {1'b0, expMsg, masterAbortReceived, targetAbortReceived, 12'h000};
        clrMask = (cfgWrite && cfgByteEn[1] && cfgAddr == bridge_regs_pkg::BRIDGE_STATUS_OFS) ?
          (cfgWriteData & 16'h7000) : 16'h0000;
        flg = (flg & ~clrMask) | setMask;
        expMsg = errorConditionEnabled & (cmdEn | secondFuncSysErrEnable);
        if (cfgWrite && cfgByteEn[1] && cfgAddr == bridge_regs_pkg::BRIDGE_COMMAND_OFS) cmdEn = cfgWriteData[8];
      end
    end
    @(negedge clock);
    check(16'(msgCount), 16'(modelMsgs));
    close_out;
  end
endmodule // test_host_bridge_command_status_regs

//--- design/bridge_regs_pkg.sv
// Package: offsets, field positions and reset values of the bridge command and status registers
package bridge_regs_pkg;
  localparam int          CFG_ADDR_W           = 8;
  localparam logic [7:0]  BRIDGE_COMMAND_OFS   = 8'h04;
  localparam logic [7:0]  BRIDGE_STATUS_OFS    = 8'h06;
  localparam logic [7:0]  CAPABILITY_POINTER_OFS = 8'h34;
  localparam logic [15:0] BRIDGE_COMMAND_RST   = 16'h0406;
  localparam logic [15:0] BRIDGE_STATUS_RST    = 16'h0090;
  // Command fields
  localparam int CMD_FAST_BACK_TO_BACK  = 9;
  localparam int CMD_SYSTEM_ERROR_EN    = 8;
  localparam int CMD_ADDR_DATA_STEPPING = 7;
  localparam int CMD_PARITY_ERR_RESP    = 6;
  localparam int CMD_PALETTE_SNOOP      = 5;
  localparam int CMD_WRITE_INVALIDATE   = 4;
  localparam int CMD_SPECIAL_CYCLE      = 3;
  localparam int CMD_BUS_MASTER_EN      = 2;
  localparam int CMD_MEMORY_ACCESS_EN   = 1;
  localparam int CMD_IO_ACCESS_EN       = 0;
  // Status fields
  localparam int STS_DETECTED_PARITY    = 15;
  localparam int STS_SIGNALLED_SYS_ERR  = 14;
  localparam int STS_RECEIVED_MASTER_AB = 13;
  localparam int STS_RECEIVED_TARGET_AB = 12;
  localparam int STS_SIGNALLED_TARGET_AB = 11;
  localparam int STS_SELECT_TIMING_MSB  = 10;
  localparam int STS_SELECT_TIMING_LSB  = 9;
  localparam int STS_MASTER_PARITY      = 8;
  localparam int STS_FAST_BACK_TO_BACK  = 7;
  localparam int STS_CAP_LIST_PRESENT   = 4;
  localparam int STS_NUM_FLAGS          = 3;
endpackage

//--- design/host_bridge_command_status_regs.sv
// Command and status configuration registers of the host-to-hub bridge function
`timescale 1ns/1ps
module host_bridge_command_status_regs (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [1:0]  cfgByteEn,
  input  wire logic [15:0] cfgWriteData,
  output logic      [15:0] cfgReadData,
  output logic             cfgReadValid,
  input  wire logic        errorConditionEnabled,
  input  wire logic        secondFuncSysErrEnable,
  input  wire logic        masterAbortReceived,
  input  wire logic        targetAbortReceived,
  output logic             sysErrMessageReq,
  output logic             systemErrorEnable
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic cmdHit;
  logic stsHit;
  logic [15:0] wrBits;
  assign cmdHit = cfgAddr == bridge_regs_pkg::BRIDGE_COMMAND_OFS;
  assign stsHit = cfgAddr == bridge_regs_pkg::BRIDGE_STATUS_OFS;
  assign wrBits = cfgWriteData & {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};

  // ----------------------------------------
  // Command register
  // ----------------------------------------
  logic next_systemErrorEnable;
  always_comb begin
    next_systemErrorEnable = systemErrorEnable;
    if (cfgWrite && cmdHit && cfgByteEn[1]) begin
      next_systemErrorEnable = wrBits[bridge_regs_pkg::CMD_SYSTEM_ERROR_EN];
    end
  end

  // ----------------------------------------
  // Command view, only bit 8 is stored
  // ----------------------------------------
  logic [15:0] commandView;
  always_comb begin
    commandView                                          = bridge_regs_pkg::BRIDGE_COMMAND_RST;
    commandView[bridge_regs_pkg::CMD_FAST_BACK_TO_BACK]  = 1'h0;
    commandView[bridge_regs_pkg::CMD_SYSTEM_ERROR_EN]    = systemErrorEnable;
    commandView[bridge_regs_pkg::CMD_ADDR_DATA_STEPPING] = 1'h0;
    commandView[bridge_regs_pkg::CMD_PARITY_ERR_RESP]    = 1'h0;
    commandView[bridge_regs_pkg::CMD_PALETTE_SNOOP]      = 1'h0;
    commandView[bridge_regs_pkg::CMD_WRITE_INVALIDATE]   = 1'h0;
    commandView[bridge_regs_pkg::CMD_SPECIAL_CYCLE]      = 1'h0;
    commandView[bridge_regs_pkg::CMD_IO_ACCESS_EN]       = 1'h0;
    commandView[bridge_regs_pkg::CMD_BUS_MASTER_EN]      = 1'h1;
    commandView[bridge_regs_pkg::CMD_MEMORY_ACCESS_EN]   = 1'h1;
  end

  // ----------------------------------------
  // System error message
  // ----------------------------------------
  logic next_sysErrMessageReq;
  logic messagingEnabled;
  assign messagingEnabled = systemErrorEnable | secondFuncSysErrEnable;
  always_comb begin
    next_sysErrMessageReq = errorConditionEnabled & messagingEnabled;
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic [2:0] flagSet;
  logic [2:0] flagClear;
  logic [2:0] flags;
  always_comb begin
    flagSet = {sysErrMessageReq, masterAbortReceived, targetAbortReceived};
    flagClear = '0;
    if (cfgWrite && stsHit && cfgByteEn[1]) begin
      flagClear = wrBits[bridge_regs_pkg::STS_SIGNALLED_SYS_ERR:bridge_regs_pkg::STS_RECEIVED_TARGET_AB];
    end
  end

  sticky_flag_bank #(
    .N (bridge_regs_pkg::STS_NUM_FLAGS)
  ) u_flags (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .setEvent  (flagSet),
    .clearMask (flagClear),
    .flags     (flags)
  );

  // ----------------------------------------
  // Status view
  // ----------------------------------------
  logic [15:0] statusView;
  always_comb begin
    statusView                                          = bridge_regs_pkg::BRIDGE_STATUS_RST;
    statusView[bridge_regs_pkg::STS_DETECTED_PARITY]     = 1'h0;
    statusView[bridge_regs_pkg::STS_SIGNALLED_SYS_ERR]   = flags[2];
    statusView[bridge_regs_pkg::STS_RECEIVED_MASTER_AB]  = flags[1];
    statusView[bridge_regs_pkg::STS_RECEIVED_TARGET_AB]  = flags[0];
    statusView[bridge_regs_pkg::STS_SIGNALLED_TARGET_AB] = 1'h0;
    statusView[bridge_regs_pkg::STS_SELECT_TIMING_MSB]   = 1'h0;
    statusView[bridge_regs_pkg::STS_SELECT_TIMING_LSB]   = 1'h0;
    statusView[bridge_regs_pkg::STS_MASTER_PARITY]       = 1'h0;
    statusView[bridge_regs_pkg::STS_FAST_BACK_TO_BACK]   = 1'h1;
    statusView[bridge_regs_pkg::STS_CAP_LIST_PRESENT]    = 1'h1;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0] next_cfgReadData;
  logic        next_cfgReadValid;
  always_comb begin
    next_cfgReadValid = cfgRead;
    next_cfgReadData  = 16'h0000;
    if (cfgRead && cmdHit) begin
      next_cfgReadData = commandView;
    end else if (cfgRead && stsHit) begin
      next_cfgReadData = statusView;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      systemErrorEnable <= 1'h0;
    end else begin
      systemErrorEnable <= next_systemErrorEnable;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sysErrMessageReq <= 1'h0;
    end else begin
      sysErrMessageReq <= next_sysErrMessageReq;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfgReadData  <= 16'h0000;
      cfgReadValid <= 1'h0;
    end else begin
      cfgReadData  <= next_cfgReadData;
      cfgReadValid <= next_cfgReadValid;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cmd_read_value: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> cfgReadData == {6'h01, 1'h0, $past(systemErrorEnable), 8'h06})
    else $error("command read value wrong");
  a_sts_fixed_bits: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=> (cfgReadData & 16'h8FFF) == 16'h0090)
    else $error("status fixed bits wrong");
  a_serr_gated: assert property (@(posedge clock) disable iff (sys_rst)
    errorConditionEnabled && !systemErrorEnable && !secondFuncSysErrEnable |=> !sysErrMessageReq)
    else $error("message sent while disabled");
  a_serr_sent: assert property (@(posedge clock) disable iff (sys_rst)
    errorConditionEnabled && (systemErrorEnable || secondFuncSysErrEnable) |=> sysErrMessageReq)
    else $error("message not sent");
  a_sys_err_flag: assert property (@(posedge clock) disable iff (sys_rst)
    sysErrMessageReq |=> flags[2])
    else $error("signalled error flag not set");
  a_master_abort_flag: assert property (@(posedge clock) disable iff (sys_rst)
    masterAbortReceived |=> flags[1])
    else $error("master abort flag not set");
  a_target_abort_flag: assert property (@(posedge clock) disable iff (sys_rst)
    targetAbortReceived |=> flags[0])
    else $error("target abort flag not set");
  a_flag_clears: assert property (@(posedge clock) disable iff (sys_rst)
    cfgWrite && stsHit && cfgByteEn[1] && cfgWriteData[12] && !targetAbortReceived |=> !flags[0])
    else $error("target abort flag not cleared");
  a_enable_write: assert property (@(posedge clock) disable iff (sys_rst)
    cfgWrite && cmdHit && cfgByteEn[1] |=> systemErrorEnable == $past(cfgWriteData[8]))
    else $error("enable write lost");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && !cmdHit && !stsHit |=> cfgReadData == 16'h0000 && cfgReadValid)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // Command checks
  // ----------------------------------------
  a_cmd_reset_read: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit && !systemErrorEnable |=> cfgReadData == bridge_regs_pkg::BRIDGE_COMMAND_RST)
    else $error("command reset value wrong");
  a_cmd_fast_bit: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> !cfgReadData[bridge_regs_pkg::CMD_FAST_BACK_TO_BACK])
    else $error("command fast back-to-back bit set");
  a_cmd_step_parity: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> cfgReadData[7:5] == 3'h0)
    else $error("command bits 7 to 5 not zero");
  a_cmd_unused_low: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> cfgReadData[4:3] == 2'h0 && !cfgReadData[bridge_regs_pkg::CMD_IO_ACCESS_EN])
    else $error("command bits 4, 3, 0 not zero");
  a_cmd_bus_master: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> cfgReadData[bridge_regs_pkg::CMD_BUS_MASTER_EN])
    else $error("bus master enable not one");
  a_cmd_mem_access: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> cfgReadData[bridge_regs_pkg::CMD_MEMORY_ACCESS_EN])
    else $error("memory access enable not one");
  a_cmd_reserved: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && cmdHit |=> (cfgReadData & 16'hF800) == 16'h0000)
    else $error("command reserved bits set");
  a_enable_kept: assert property (@(posedge clock) disable iff (sys_rst)
    !(cfgWrite && cmdHit && cfgByteEn[1]) |=> $stable(systemErrorEnable))
    else $error("enable changed without write");
  a_enable_reset: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> !systemErrorEnable)
    else $error("enable not cleared by reset");

  // ----------------------------------------
  // Status checks
  // ----------------------------------------
  a_sts_reserved: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=> (cfgReadData & 16'h006F) == 16'h0000)
    else $error("status reserved bits set");
  a_sts_never_set: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=> (cfgReadData & 16'h8900) == 16'h0000)
    else $error("status bits 15, 11, 8 not zero");
  a_sts_timing: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=>
      cfgReadData[bridge_regs_pkg::STS_SELECT_TIMING_MSB:bridge_regs_pkg::STS_SELECT_TIMING_LSB] == 2'h0)
    else $error("select timing not fast");
  a_sts_fast_bit: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=> cfgReadData[bridge_regs_pkg::STS_FAST_BACK_TO_BACK])
    else $error("fast back-to-back capability not one");
  a_sts_cap_list: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=> cfgReadData[bridge_regs_pkg::STS_CAP_LIST_PRESENT])
    else $error("capability list bit not one");
  a_sts_flag_view: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead && stsHit |=>
      cfgReadData[bridge_regs_pkg::STS_SIGNALLED_SYS_ERR:bridge_regs_pkg::STS_RECEIVED_TARGET_AB] == $past(flags))
    else $error("status flags read wrong");
  a_sys_err_clears: assert property (@(posedge clock) disable iff (sys_rst)
    cfgWrite && stsHit && cfgByteEn[1] && cfgWriteData[bridge_regs_pkg::STS_SIGNALLED_SYS_ERR] &&
      !sysErrMessageReq |=> !flags[2])
    else $error("signalled error flag not cleared");
  a_master_abort_clears: assert property (@(posedge clock) disable iff (sys_rst)
    cfgWrite && stsHit && cfgByteEn[1] && cfgWriteData[bridge_regs_pkg::STS_RECEIVED_MASTER_AB] &&
      !masterAbortReceived |=> !flags[1])
    else $error("master abort flag not cleared");
  a_flags_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !sysErrMessageReq && !masterAbortReceived && !targetAbortReceived &&
      !(cfgWrite && stsHit && cfgByteEn[1]) |=> $stable(flags))
    else $error("status flags changed without cause");
  a_low_byte_keep: assert property (@(posedge clock) disable iff (sys_rst)
    cfgWrite && stsHit && !cfgByteEn[1] |=> ($past(flags) & ~flags) == 3'h0)
    else $error("low byte write cleared a flag");
  a_sys_err_cause: assert property (@(posedge clock) disable iff (sys_rst)
    !flags[2] && !sysErrMessageReq |=> !flags[2])
    else $error("signalled error flag set without message");
  a_master_abort_cause: assert property (@(posedge clock) disable iff (sys_rst)
    !flags[1] && !masterAbortReceived |=> !flags[1])
    else $error("master abort flag set without event");
  a_target_abort_cause: assert property (@(posedge clock) disable iff (sys_rst)
    !flags[0] && !targetAbortReceived |=> !flags[0])
    else $error("target abort flag set without event");
  a_flags_reset: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> flags == 3'h0)
    else $error("status flags not cleared by reset");

  // ----------------------------------------
  // Message and read path checks
  // ----------------------------------------
  a_msg_own_enable: assert property (@(posedge clock) disable iff (sys_rst)
    errorConditionEnabled && systemErrorEnable |=> sysErrMessageReq)
    else $error("message not sent with own enable");
  a_msg_second_enable: assert property (@(posedge clock) disable iff (sys_rst)
    errorConditionEnabled && secondFuncSysErrEnable |=> sysErrMessageReq)
    else $error("message not sent with second enable");
  a_msg_no_cause: assert property (@(posedge clock) disable iff (sys_rst)
    !errorConditionEnabled |=> !sysErrMessageReq)
    else $error("message sent without error");
  a_msg_both_off: assert property (@(posedge clock) disable iff (sys_rst)
    !systemErrorEnable && !secondFuncSysErrEnable |=> !sysErrMessageReq)
    else $error("message sent with both enables off");
  a_read_valid: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRead |=> cfgReadValid)
    else $error("read not answered");
  a_idle_zero: assert property (@(posedge clock) disable iff (sys_rst)
    !cfgRead |=> !cfgReadValid && cfgReadData == 16'h0000)
    else $error("read data not zero when idle");
  a_reset_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> !cfgReadValid && !sysErrMessageReq && cfgReadData == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule // host_bridge_command_status_regs

//--- design/sticky_flag_bank.sv
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int N = 3
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] setEvent,
  input  wire logic [N-1:0] clearMask,
  output logic      [N-1:0] flags
);
  logic [N-1:0] next_flags;

  // ----------------------------------------
  // Per-flag next value
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_comb begin
        next_flags[i] = setEvent[i] | (flags[i] & ~clearMask[i]);
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule // sticky_flag_bank
